// ### bench/rlm_monitor_tb.sv
`timescale 1ns/1ps
module rlm_monitor_tb;
    import rlm_pkg::*;
    localparam int TCK = 20;
    logic clk;
    logic rst_n;
    rlm_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    rlm_meas_t meas_in;
    rlm_tx_t limit_tx;
    logic [15:0] meas_obj;
    logic [31:0] rd_val;
    int error_cnt = 0;
    int comparisons = 0;

    rlm_monitor #(.TICK_CYCLES(TCK)) dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .meas_in(meas_in), .limit_tx(limit_tx), .meas_obj(meas_obj));
    rlm_peer peer (.clk(clk), .rst_n(rst_n), .meas_in(meas_in), .limit_tx(limit_tx));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe is dropped one edge before the next request may start
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(posedge clk);
        rd_val = bus_rdata;
        check(rd_val & m, e);
    endtask
    task automatic meas(input logic [15:0] v);
        peer.sample(v);
        repeat (4) @(posedge clk);
    endtask
    task automatic cond_is(input logic e);
        chk_rd(8'h20, 32'h4, {29'h0, e, 2'h0});
    endtask
    task automatic acc_is(input logic e);
        chk_rd(8'h20, 32'h1, {31'h0, e});
    endtask
    task automatic wait_tx(input int n);
        int i;
        i = 0;
        while (peer.tx_cnt < n && i < 2000) begin
            @(posedge clk);
            i++;
        end
        check({31'h0, i < 2000}, 32'h1);
    endtask
    task automatic until_cyc(input realtime t0, input int n);
        while ($realtime < t0 + n * 20.0) @(posedge clk);
    endtask

    task automatic t_reset();
        chk_rd(8'h00, 32'hFFFFFFFF, 32'h14);
        chk_rd(8'h08, 32'hFFFFFFFF, 32'h1F4);
        chk_rd(8'h20, 32'hFFF30, 32'h0);
        chk_rd(8'h30, 32'hFFFFFFFF, 32'h0);
        wr(8'h08, 32'd100);
        chk_rd(8'h08, 32'hFFFF, 32'h12C);
        wr(8'h08, 32'd2000);
        chk_rd(8'h08, 32'hFFFF, 32'h514);
        wr(8'h08, 32'd500);
        $display("test reset done");
    endtask
    task automatic t_change();
        int c;
        wr(8'h0C, 32'd50);
        c = peer.tx_cnt;
        meas(16'd600);
        wait_tx(c + 1);
        check({31'h0, peer.tx_val}, 32'h1);
        check({24'h0, peer.tx_obj}, 32'h35);
        check({16'h0, meas_obj}, 32'h2F53);
        chk_rd(8'h1C, 32'hFFFF, 32'd600);
        meas(16'd470);
        cond_is(1'b1);
        meas(16'd440);
        wait_tx(c + 2);
        check({31'h0, peer.tx_val}, 32'h0);
        wr(8'h0C, 32'd0);
        $display("test change done");
    endtask
    task automatic t_on_delay();
        realtime t0;
        int c;
        wr(8'h00, 32'h0610);
        wr(8'h04, 32'd1);
        t0 = $realtime;
        c = peer.tx_cnt;
        meas(16'd600);
        wait_tx(c + 2);
        check({31'h0, peer.tx_val}, 32'h0);
        until_cyc(t0, 600);
        acc_is(1'b0);
        until_cyc(t0, 640);
        acc_is(1'b1);
        wait_tx(peer.tx_cnt + 1);
        check({31'h0, peer.tx_val}, 32'h1);
        $display("test on delay done");
    endtask
    task automatic t_off_delay();
        realtime t0;
        wr(8'h00, 32'h8014);
        t0 = $realtime;
        meas(16'd400);
        wait_tx(peer.tx_cnt + 1);
        check({31'h0, peer.tx_val}, 32'h1);
        until_cyc(t0, 3600);
        acc_is(1'b1);
        until_cyc(t0, 3640);
        acc_is(1'b0);
        $display("test off delay done");
    endtask
    task automatic t_cancel();
        int c;
        wr(8'h04, 32'd0);
        wr(8'h00, 32'h0414);
        c = peer.tx_cnt;
        meas(16'd600);
        repeat (50) @(posedge clk);
        meas(16'd400);
        repeat (300) @(posedge clk);
        check(peer.tx_cnt, c);
        acc_is(1'b0);
        $display("test cancel done");
    endtask
    task automatic t_quiet();
        int c;
        wr(8'h00, 32'h0024);
        wr(8'h04, 32'd1);
        c = peer.tx_cnt;
        meas(16'd600);
        repeat (450) @(posedge clk);
        check(peer.tx_cnt, c);
        meas(16'd400);
        wr(8'h00, 32'h0010);
        wr(8'h04, 32'd0);
        // a cyclic send launched beside the write must be counted before the snapshot
        repeat (2) @(posedge clk);
        c = peer.tx_cnt;
        meas(16'd600);
        repeat (450) @(posedge clk);
        check(peer.tx_cnt, c);
        acc_is(1'b1);
        $display("test quiet done");
    endtask
    task automatic t_ext();
        wr(8'h00, 32'h0015);
        wr(8'h10, 32'h33E8);
        cond_is(1'b0);
        meas(16'd700);
        cond_is(1'b1);
        wr(8'h00, 32'h0016);
        wr(8'h14, 32'd51);
        meas(16'd350);
        cond_is(1'b0);
        meas(16'd450);
        cond_is(1'b1);
        meas(16'd350);
        wr(8'h18, 32'h2);
        meas(16'd450);
        cond_is(1'b0);
        chk_rd(8'h20, 32'h40, 32'h0);
        wr(8'h00, 32'h0017);
        meas(16'd800);
        wr(8'h18, 32'h1);
        meas(16'd750);
        cond_is(1'b0);
        meas(16'd850);
        cond_is(1'b1);
        $display("test external limit done");
    endtask
    task automatic t_under();
        wr(8'h0C, 32'd50);
        wr(8'h00, 32'h001C);
        meas(16'd480);
        cond_is(1'b1);
        meas(16'd520);
        cond_is(1'b1);
        acc_is(1'b1);
        meas(16'd560);
        cond_is(1'b0);
        $display("test undershoot done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_change();
        t_on_delay();
        t_off_delay();
        t_cancel();
        t_quiet();
        t_ext();
        t_under();
        print_verdict();
    end

    // all scenarios together need roughly six thousand cycles
    initial begin
        #(20 * 40000);
        error_cnt++;
        print_verdict();
    end
endmodule

// ### bench/rlm_peer.sv
`timescale 1ns/1ps
module rlm_peer
    import rlm_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_n,
    // sensor side
    output rlm_pkg::rlm_meas_t meas_in,
    // bus objects heard on the line
    input wire rlm_pkg::rlm_tx_t limit_tx
);
    int tx_cnt = 0;
    logic tx_val = 1'b0;
    logic [7:0] tx_obj = 8'h00;
    initial meas_in = '0;
    // a bus peer only sees telegrams, so it keeps the last one heard
    always @(posedge clk) begin
        if (rst_n === 1'b1 && limit_tx.req === 1'b1) begin
            tx_cnt <= tx_cnt + 1;
            tx_val <= limit_tx.value;
            tx_obj <= limit_tx.obj;
        end
    end
    // sensor keeps its last value, the strobe marks a fresh sample
    task automatic sample(input logic [15:0] v);
        meas_in <= {1'b1, v};
        @(posedge clk);
        meas_in.valid <= 1'b0;
    endtask
endmodule

// ### design/rlm_float_enc.sv
`timescale 1ns/1ps
module rlm_float_enc (
    // unsigned integer in W/m2
    input wire logic [15:0] value,
    // two-byte float: sign, 4-bit exponent, 11-bit mantissa, unit 0.01
    output logic [15:0] encoded
);
    logic [22:0] scaled;
    logic [22:0] mant;
    logic [3:0] expo;

    always_comb begin
        scaled = 23'(value) * 23'd100;
        mant = scaled;
        expo = 4'h0;
        // smallest exponent whose mantissa fits the positive 11-bit range
        for (int i = 0; i < 15; i++) begin
            if (mant > 23'h0007FF) begin
                mant = mant >> 1;
                expo = expo + 4'h1;
            end
        end
        encoded = {1'b0, expo, mant[10:0]};
    end
endmodule

// ### design/rlm_monitor.sv
`timescale 1ns/1ps
`include "rlm_cfg.svh"

module rlm_monitor
    import rlm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `RLM_TICK_S * `RLM_CLK_HZ
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire rlm_pkg::rlm_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // sensor
    input wire rlm_pkg::rlm_meas_t meas_in,
    // bus objects
    output rlm_pkg::rlm_tx_t limit_tx,
    output logic [15:0] meas_obj
);
    import rlm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    function automatic logic [11:0] delay_secs(input logic [3:0] sel, input logic off);
        logic [3:0] s;
        s = sel;
        // the switch-on list has no 3-minute entry, so later codes shift by one
        if (!off && sel >= 4'h8 && sel != 4'hF) s = sel + 4'h1;
        case (s)
            4'h0: delay_secs = 12'h000;
            4'h1: delay_secs = 12'h001;
            4'h2: delay_secs = 12'h003;
            4'h3: delay_secs = 12'h005;
            4'h4: delay_secs = 12'h00A;
            4'h5: delay_secs = 12'h00F;
            4'h6: delay_secs = 12'h01E;
            4'h7: delay_secs = 12'h03C;
            4'h8: delay_secs = 12'h0B4;
            4'h9: delay_secs = 12'h12C;
            4'hA: delay_secs = 12'h258;
            4'hB: delay_secs = 12'h384;
            4'hC: delay_secs = 12'h708;
            default: delay_secs = 12'hE10;
        endcase
    endfunction

    // two-byte float to whole W/m2; negative values clamp to zero
    function automatic logic [15:0] float_to_int(input logic [15:0] f);
        logic [26:0] m;
        logic [26:0] q;
        m = 27'(f[10:0]) << f[14:11];
        q = m / 27'd100;
        if (f[15]) float_to_int = 16'h0000;
        else if (q > 27'h000FFFF) float_to_int = 16'hFFFF;
        else float_to_int = q[15:0];
    endfunction

    function automatic logic [15:0] pct_to_int(input logic [7:0] p);
        logic [23:0] prod;
        prod = 24'(p) * 24'(`RLM_UPPER_RANGE) / 24'd255;
        pct_to_int = prod[15:0];
    endfunction

    function automatic logic [15:0] clamp_limit(input logic [15:0] v);
        if (v < `RLM_LIMIT_MIN) clamp_limit = `RLM_LIMIT_MIN;
        else if (v > `RLM_LIMIT_MAX) clamp_limit = `RLM_LIMIT_MAX;
        else clamp_limit = v;
    endfunction

    rlm_ctrl_t ctrl;
    logic [6:0] cycle;
    logic [15:0] limit_cfg;
    logic [15:0] hyst;
    logic [15:0] ext_limit;
    logic ext_valid;
    logic [15:0] meas;
    logic [15:0] meas_enc;
    logic [15:0] limit_eff;
    logic tick;
    logic cond;
    logic target;
    logic acc;
    logic acc_d;
    logic silent;
    rlm_act_t act_now;
    rlm_dly_state_t state;
    logic [11:0] dly_cnt;
    logic [10:0] cyc_cnt;
    logic [10:0] cyc_secs;
    logic cyc_fire;
    logic enter;
    logic leave;
    logic wr_ctrl, wr_cycle, wr_limit, wr_hyst, wr_ext16, wr_ext8, wr_cmd;

    rlm_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    rlm_float_enc u_enc (
        .value(meas),
        .encoded(meas_enc)
    );

    always_comb begin
        wr_ctrl = bus_req.wr && bus_req.addr == `RLM_OFS_CTRL;
        wr_cycle = bus_req.wr && bus_req.addr == `RLM_OFS_CYCLE;
        wr_limit = bus_req.wr && bus_req.addr == `RLM_OFS_LIMIT;
        wr_hyst = bus_req.wr && bus_req.addr == `RLM_OFS_HYST;
        wr_ext16 = bus_req.wr && bus_req.addr == `RLM_OFS_EXT16;
        wr_ext8 = bus_req.wr && bus_req.addr == `RLM_OFS_EXT8;
        wr_cmd = bus_req.wr && bus_req.addr == `RLM_OFS_CMD;
    end

    // configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= rlm_ctrl_t'(`RLM_CTRL_RST);
            cycle <= `RLM_CYCLE_RST;
            limit_cfg <= `RLM_LIMIT_RST;
            hyst <= `RLM_HYST_RST;
        end else begin
            if (wr_ctrl) ctrl <= rlm_ctrl_t'(bus_req.wdata[15:0]);
            if (wr_cycle) begin
                if (bus_req.wdata[6:0] > `RLM_CYCLE_MAX) cycle <= `RLM_CYCLE_MAX;
                else cycle <= bus_req.wdata[6:0];
            end
            if (wr_limit) limit_cfg <= clamp_limit(bus_req.wdata[15:0]);
            if (wr_hyst) hyst <= bus_req.wdata[15:0];
        end
    end

    // external threshold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_limit <= 16'h0000;
            ext_valid <= 1'b0;
        end else if (wr_cmd && bus_req.wdata[`RLM_CMD_DOWNLOAD]) begin
            ext_valid <= 1'b0;
        end else if (wr_ext16 && ctrl.ext_src == RLM_EXT_WIDE) begin
            ext_limit <= float_to_int(bus_req.wdata[15:0]);
            ext_valid <= 1'b1;
        end else if (wr_ext8 && ctrl.ext_src == RLM_EXT_NARROW) begin
            ext_limit <= pct_to_int(bus_req.wdata[7:0]);
            ext_valid <= 1'b1;
        end else if (wr_cmd && bus_req.wdata[`RLM_CMD_TEACH]
                     && ctrl.ext_src == RLM_EXT_TEACH) begin
            ext_limit <= meas;
            ext_valid <= 1'b1;
        end
    end

    // an external value outlives a later change of source only until download
    assign limit_eff = (ext_valid && ctrl.ext_src != RLM_EXT_NONE) ? ext_limit : limit_cfg;

    // measurement and its object
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meas <= 16'h0000;
            meas_obj <= 16'h0000;
        end else begin
            if (meas_in.valid) meas <= meas_in.value;
            meas_obj <= meas_enc;
        end
    end

    // comparator with hysteresis on the return crossing
    always_comb begin
        if (ctrl.undershoot) begin
            enter = meas < limit_eff;
            leave = {1'b0, meas} > {1'b0, limit_eff} + {1'b0, hyst};
        end else begin
            enter = meas > limit_eff;
            leave = {1'b0, meas} + {1'b0, hyst} < {1'b0, limit_eff};
        end
        act_now = cond ? ctrl.ent_act : ctrl.ret_act;
        silent = !(act_now == RLM_ACT_ON || act_now == RLM_ACT_OFF);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond <= 1'b0;
            target <= 1'b0;
        end else begin
            if (enter) cond <= 1'b1;
            else if (leave) cond <= 1'b0;
            if (!silent) target <= act_now == RLM_ACT_ON;
        end
    end

    // switch-on and switch-off delay; one extra tick because the tick runs free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RLM_IDLE;
            dly_cnt <= 12'h000;
            acc <= 1'b0;
        end else begin
            case (state)
                RLM_IDLE: begin
                    dly_cnt <= 12'h000;
                    if (target && !acc) begin
                        if (delay_secs(ctrl.on_sel, 1'b0) == 12'h000) acc <= 1'b1;
                        else state <= RLM_ON_WAIT;
                    end else if (!target && acc) begin
                        if (delay_secs(ctrl.off_sel, 1'b1) == 12'h000) acc <= 1'b0;
                        else state <= RLM_OFF_WAIT;
                    end
                end
                RLM_ON_WAIT: begin
                    if (!target) begin
                        state <= RLM_IDLE;
                    end else if (tick) begin
                        if (dly_cnt >= delay_secs(ctrl.on_sel, 1'b0)) begin
                            acc <= 1'b1;
                            state <= RLM_IDLE;
                        end else begin
                            dly_cnt <= dly_cnt + 12'h001;
                        end
                    end
                end
                RLM_OFF_WAIT: begin
                    if (target) begin
                        state <= RLM_IDLE;
                    end else if (tick) begin
                        if (dly_cnt >= delay_secs(ctrl.off_sel, 1'b1)) begin
                            acc <= 1'b0;
                            state <= RLM_IDLE;
                        end else begin
                            dly_cnt <= dly_cnt + 12'h001;
                        end
                    end
                end
                default: state <= RLM_IDLE;
            endcase
        end
    end

    // cyclic repeat timer
    assign cyc_secs = 11'(cycle) * 11'(`RLM_CYCLE_STEP_S);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_cnt <= 11'h000;
            cyc_fire <= 1'b0;
        end else begin
            cyc_fire <= 1'b0;
            if (cycle == 7'h00) begin
                cyc_cnt <= 11'h000;
            end else if (tick) begin
                if (cyc_cnt + 11'h001 >= cyc_secs) begin
                    cyc_cnt <= 11'h000;
                    cyc_fire <= 1'b1;
                end else begin
                    cyc_cnt <= cyc_cnt + 11'h001;
                end
            end
        end
    end

    // limit object carries the accepted state, so a running delay repeats the old one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_d <= 1'b0;
            limit_tx <= '0;
        end else begin
            acc_d <= acc;
            limit_tx.obj <= `RLM_OBJ_LIMIT;
            limit_tx.value <= acc;
            limit_tx.req <= ((acc != acc_d) && ctrl.send_on_change)
                || (cyc_fire && !silent);
        end
    end

    // register read, data valid one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            if (bus_req.addr == `RLM_OFS_CTRL) bus_rdata <= {16'h0000, ctrl};
            else if (bus_req.addr == `RLM_OFS_CYCLE) bus_rdata <= {25'h0000000, cycle};
            else if (bus_req.addr == `RLM_OFS_LIMIT) bus_rdata <= {16'h0000, limit_cfg};
            else if (bus_req.addr == `RLM_OFS_HYST) bus_rdata <= {16'h0000, hyst};
            else if (bus_req.addr == `RLM_OFS_EXT16) bus_rdata <= {16'h0000, ext_limit};
            else if (bus_req.addr == `RLM_OFS_MEAS) bus_rdata <= {16'h0000, meas};
            else if (bus_req.addr == `RLM_OFS_MEASF) bus_rdata <= {16'h0000, meas_obj};
            else if (bus_req.addr == `RLM_OFS_STATUS)
                bus_rdata <= {12'h000, dly_cnt, 1'b0, ext_valid, state, silent, cond, target, acc};
            else bus_rdata <= 32'h0000_0000;
        end
    end

    property p_on_delay;
        $rose(acc) && delay_secs(ctrl.on_sel, 1'b0) != 12'h000
            |-> $past(state) == RLM_ON_WAIT && $past(tick);
    endproperty
    a_on_delay: assert property (p_on_delay) else $error("early switch-on");
    property p_on_hold;
        state == RLM_ON_WAIT |-> !acc;
    endproperty
    a_on_hold: assert property (p_on_hold) else $error("one sent during on delay");
    property p_off_delay;
        $fell(acc) && delay_secs(ctrl.off_sel, 1'b1) != 12'h000
            |-> $past(state) == RLM_OFF_WAIT && $past(tick);
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("early switch-off");
    property p_off_hold;
        state == RLM_OFF_WAIT |-> acc;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("zero sent during off delay");
    property p_change_send;
        $changed(acc) && ctrl.send_on_change |=> limit_tx.req && limit_tx.value == $past(acc);
    endproperty
    a_change_send: assert property (p_change_send) else $error("toggle not sent");
    property p_never_send;
        (!ctrl.send_on_change && cycle == 7'h00) [*3] |-> !limit_tx.req;
    endproperty
    a_never_send: assert property (p_never_send) else $error("send while disabled");
    property p_download;
        wr_cmd && bus_req.wdata[`RLM_CMD_DOWNLOAD] |=> !ext_valid && limit_eff == limit_cfg;
    endproperty
    a_download: assert property (p_download) else $error("external limit kept");
    property p_teach;
        wr_cmd && bus_req.wdata[`RLM_CMD_TEACH] && !bus_req.wdata[`RLM_CMD_DOWNLOAD]
            && ctrl.ext_src == RLM_EXT_TEACH |=> ext_valid && limit_eff == $past(meas);
    endproperty
    a_teach: assert property (p_teach) else $error("teach not latched");
    property p_cancel;
        state == RLM_ON_WAIT && !target |=> state == RLM_IDLE && !acc;
    endproperty
    a_cancel: assert property (p_cancel) else $error("on delay not cancelled");
    property p_limit_range;
        limit_cfg >= `RLM_LIMIT_MIN && limit_cfg <= `RLM_LIMIT_MAX;
    endproperty
    a_limit_range: assert property (p_limit_range) else $error("limit out of range");
    property p_cyc_off;
        (cycle == 7'h00) [*2] |-> !cyc_fire;
    endproperty
    a_cyc_off: assert property (p_cyc_off) else $error("cyclic send at zero");
    c_on_accept: cover property (state == RLM_ON_WAIT ##1 $rose(acc));
    c_cancel: cover property (state == RLM_OFF_WAIT ##1 state == RLM_IDLE && acc);
    c_cyclic: cover property (cyc_fire ##1 limit_tx.req);
    c_silent: cover property (cyc_fire && silent);
endmodule

// ### design/rlm_tick_gen.sv
`timescale 1ns/1ps
module rlm_tick_gen #(
    parameter int unsigned CYCLES = 50000000
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // one-cycle pulse once per period
    output logic tick
);
    logic [31:0] cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt >= CYCLES - 1) begin
            cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule

// ### pkg/rlm_cfg.svh
`ifndef RLM_CFG_SVH
`define RLM_CFG_SVH

// clock and time base
`define RLM_CLK_HZ 50000000
`define RLM_TICK_S 1
`define RLM_CYCLE_STEP_S 10
`define RLM_CYCLE_MAX 7'h78

// register offsets (byte addresses on the plain register port)
`define RLM_OFS_CTRL 8'h00
`define RLM_OFS_CYCLE 8'h04
`define RLM_OFS_LIMIT 8'h08
`define RLM_OFS_HYST 8'h0C
`define RLM_OFS_EXT16 8'h10
`define RLM_OFS_EXT8 8'h14
`define RLM_OFS_CMD 8'h18
`define RLM_OFS_MEAS 8'h1C
`define RLM_OFS_STATUS 8'h20
`define RLM_OFS_MEASF 8'h24

// command register bits
`define RLM_CMD_TEACH 0
`define RLM_CMD_DOWNLOAD 1

// reset values
`define RLM_CTRL_RST 16'h0014
`define RLM_CYCLE_RST 7'h00
`define RLM_LIMIT_RST 16'h01F4
`define RLM_HYST_RST 16'h0000

// threshold range and percent full scale
`define RLM_LIMIT_MIN 16'h012C
`define RLM_LIMIT_MAX 16'h0514
`define RLM_UPPER_RANGE 16'h07D0

// object numbers
`define RLM_OBJ_MEAS 8'h0A
`define RLM_OBJ_LIMIT 8'h35

`endif

// ### pkg/rlm_pkg.sv
package rlm_pkg;

    typedef enum logic [1:0] {
        RLM_EXT_NONE,
        RLM_EXT_WIDE,
        RLM_EXT_NARROW,
        RLM_EXT_TEACH
    } rlm_ext_src_t;

    typedef enum logic [1:0] {
        RLM_ACT_OFF,
        RLM_ACT_ON,
        RLM_ACT_NONE
    } rlm_act_t;

    typedef enum logic [1:0] {
        RLM_IDLE,
        RLM_ON_WAIT,
        RLM_OFF_WAIT
    } rlm_dly_state_t;

    typedef struct packed {
        logic [3:0] off_sel;
        logic [3:0] on_sel;
        rlm_act_t ret_act;
        rlm_act_t ent_act;
        logic undershoot;
        logic send_on_change;
        rlm_ext_src_t ext_src;
    } rlm_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rlm_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } rlm_meas_t;

    typedef struct packed {
        logic req;
        logic [7:0] obj;
        logic value;
    } rlm_tx_t;

endpackage
